/* verilog/psc_pkg.sv */
// Constants shared by the polyphase scaler core and its self-checking bench.
// Assumes a single 40 MHz APB clock domain for control and video.
package psc_pkg;
	// Datapath widths; coefficients are sign, one integer and seven fraction bits
	localparam int SZW     = 12;
	localparam int DW      = 8;
	localparam int CW      = 9;
	localparam int CFRAC   = 7;
	localparam int KW      = 10;
	localparam int NV      = 4;
	localparam int NH      = 4;
	localparam int PV_LOG2 = 2;
	localparam int PH_LOG2 = 2;
	localparam int BKW     = 1;
	localparam int CV      = 1 << BKW;
	localparam int CH      = 1 << BKW;
	localparam int VMUL_W  = (DW > CW) ? DW : CW;
	localparam int HMUL_W  = (KW > CW) ? KW : CW;
	localparam int VDEPTH  = (1 << PV_LOG2) * NV * CV;
	localparam int HDEPTH  = (1 << PH_LOG2) * CH;
	localparam int LB_AW   = 6;
	localparam int LB_DEPTH = 1 << LB_AW;
	localparam bit SHARE_COEF = 1'b0;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_INSZ  = 8'h08;
	localparam logic [7:0] OFF_OUTSZ = 8'h0C;
	localparam logic [7:0] OFF_BANK  = 8'h10;
	localparam logic [7:0] OFF_CADDR = 8'h14;
	localparam logic [7:0] OFF_VCOEF = 8'h18;
	localparam logic [7:0] OFF_HCOEF = 8'h1C;

	// Field positions
	localparam int CTRL_GO  = 0;
	localparam int CTRL_SYM = 1;
	localparam int BANK_RD  = 0;
	localparam int BANK_WR  = 8;
	localparam int SZ_H     = 16;

	// Reset values
	localparam logic [SZW-1:0] RST_W = 12'h040;
	localparam logic [SZW-1:0] RST_H = 12'h030;

	typedef enum logic [2:0] {
		PSC_IDLE  = 3'h0,
		PSC_VLOAD = 3'h1,
		PSC_RWAIT = 3'h3,
		PSC_COLS  = 3'h2,
		PSC_OUTP  = 3'h6,
		PSC_HNORM = 3'h7,
		PSC_VNORM = 3'h5,
		PSC_DRAIN = 3'h4
	} psc_state_t;
endpackage

/* verilog/psc_mac4.sv */
// Four parallel signed multipliers and their sum.
// Assumes operands already extended to the multiplier width W.
`timescale 1ns/1ps
`default_nettype none
module psc_mac4 #(
	parameter int W = 9
) (
	input  wire logic [4*W-1:0]        a_flat,
	input  wire logic [4*W-1:0]        b_flat,
	output logic signed [2*W+1:0]      sum
);
	logic signed [2*W-1:0] prod [4];

	for (genvar g = 0; g < 4; g++) begin : g_mul
		assign prod[g] = $signed(a_flat[g*W +: W]) * $signed(b_flat[g*W +: W]);
	end

	always_comb begin
		sum = '0;
		for (int i = 0; i < 4; i++) begin
			sum = sum + (2*W+2)'(prod[i]);
		end
	end
endmodule
`default_nettype wire

/* verilog/psc_core.sv */
// Polyphase (4x4 bicubic) video scaler core with APB control and coefficients.
// Assumes video source and sink on pclk; frames start when the run bit is set.
`timescale 1ns/1ps
`default_nettype none
module psc_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [7:0]       out_data,
	output logic             out_sof,
	output logic             out_eol,
	input  wire logic        out_ready
);
	localparam int SZ   = psc_pkg::SZW;
	localparam int VA   = psc_pkg::BKW + psc_pkg::PV_LOG2 + 2;
	localparam int HA   = psc_pkg::BKW + psc_pkg::PH_LOG2;
	localparam int VM   = psc_pkg::VMUL_W;
	localparam int HM   = psc_pkg::HMUL_W;
	localparam int CW   = psc_pkg::CW;
	localparam int VSW  = 2 * VM + 2;
	localparam int HSW  = 2 * HM + 2;
	localparam logic signed [VSW-1:0] KMAX =
		VSW'((1 << (psc_pkg::KW - 1)) - 1);
	localparam logic signed [VSW-1:0] KMIN = -KMAX - VSW'(1);
	localparam logic signed [HSW-1:0] OMAX =
		HSW'((1 << psc_pkg::DW) - 1);

	psc_pkg::psc_state_t state_q;

	logic [SZ-1:0]  win_q, hin_q, wout_q, hout_q;
	logic           go_q, sym_q, rd_bank_q, wr_bank_q, act_bank_q;
	logic [3:0]     caddr_q;
	logic [SZ-1:0]  lines_q, icol_q;
	logic [SZ-1:0]  oi_q, oj_q, hq_q, vq_q;
	logic [SZ:0]    hrem_q, vrem_q;
	logic [1:0]     k_q;
	logic [CW-1:0]  vcoef_q [psc_pkg::NV];
	logic [psc_pkg::KW-1:0] hreg_q [psc_pkg::NH];
	logic [31:0]    prdata_q;
	logic           pready_q, pslverr_q, in_ready_q;
	logic           out_valid_q, out_sof_q, out_eol_q;
	logic [7:0]     out_data_q;

	logic [psc_pkg::DW-1:0] lbuf [psc_pkg::NV][psc_pkg::LB_DEPTH];
	logic [CW*psc_pkg::NH-1:0] hmem [psc_pkg::HDEPTH];

	// Restoring division: floor(rem * 2^nb / w), valid while rem < w
	function automatic logic [3:0] frac_phase(input logic [SZ:0] rem,
		input logic [SZ-1:0] w, input int nb);
		logic [SZ+1:0] r;
		logic [3:0]    p;
		r = {1'b0, rem};
		p = '0;
		for (int b = 3; b >= 0; b--) begin
			if (b < nb) begin
				r = r << 1;
				if (r >= {2'b00, w}) begin
					p[b] = 1'b1;
					r = r - {2'b00, w};
				end
			end
		end
		return p;
	endfunction

	// Source index c-1+t, clamped to 0..n-1 at the image edges
	function automatic logic [SZ-1:0] tap_pos(input logic [SZ-1:0] c,
		input logic [1:0] t, input logic [SZ-1:0] n);
		logic [SZ:0] v;
		v = {1'b0, c} + {{(SZ-1){1'b0}}, t};
		if (v == '0) return '0;
		v = v - (SZ+1)'(1);
		if (v >= {1'b0, n}) return n - SZ'(1);
		return v[SZ-1:0];
	endfunction

	// APB decode
	wire setup    = psel & ~penable;
	wire access   = psel & penable & pready_q;
	wire hit_ctrl = paddr == psc_pkg::OFF_CTRL;
	wire hit_stat = paddr == psc_pkg::OFF_STAT;
	wire hit_insz = paddr == psc_pkg::OFF_INSZ;
	wire hit_osz  = paddr == psc_pkg::OFF_OUTSZ;
	wire hit_bank = paddr == psc_pkg::OFF_BANK;
	wire hit_cadr = paddr == psc_pkg::OFF_CADDR;
	wire hit_vcf  = paddr == psc_pkg::OFF_VCOEF;
	wire hit_hcf  = paddr == psc_pkg::OFF_HCOEF;
	wire mapped   = hit_ctrl | hit_stat | hit_insz | hit_osz | hit_bank |
		hit_cadr | hit_vcf | hit_hcf;
	wire wr       = access & pwrite & mapped;
	wire busy     = state_q != psc_pkg::PSC_IDLE;

	wire [31:0] rd_mux =
		hit_ctrl ? 32'({sym_q, go_q}) :
		hit_stat ? {4'h0, lines_q, 14'h0000, act_bank_q, busy} :
		hit_insz ? {4'h0, hin_q, 4'h0, win_q} :
		hit_osz  ? {4'h0, hout_q, 4'h0, wout_q} :
		hit_bank ? 32'({wr_bank_q, 7'h00, rd_bank_q}) :
		hit_cadr ? 32'(caddr_q) : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_q      <= 1'b0;
			sym_q     <= 1'b0;
			rd_bank_q <= 1'b0;
			wr_bank_q <= 1'b0;
			caddr_q   <= 4'h0;
			win_q     <= psc_pkg::RST_W;
			wout_q    <= psc_pkg::RST_W;
			hin_q     <= psc_pkg::RST_H;
			hout_q    <= psc_pkg::RST_H;
		end else if (wr) begin
			if (hit_ctrl) begin
				go_q  <= pwdata[psc_pkg::CTRL_GO];
				sym_q <= pwdata[psc_pkg::CTRL_SYM];
			end
			if (hit_bank) begin
				rd_bank_q <= pwdata[psc_pkg::BANK_RD];
				wr_bank_q <= pwdata[psc_pkg::BANK_WR];
			end
			if (hit_cadr) caddr_q <= pwdata[3:0];
			if (hit_insz) begin
				win_q <= pwdata[SZ-1:0];
				hin_q <= pwdata[psc_pkg::SZ_H +: SZ];
			end
			if (hit_osz) begin
				wout_q <= pwdata[SZ-1:0];
				hout_q <= pwdata[psc_pkg::SZ_H +: SZ];
			end
		end
	end

	// Phases and symmetric folding
	wire [3:0] vph_w = frac_phase(vrem_q, hout_q, psc_pkg::PV_LOG2);
	wire [3:0] hph_w = frac_phase(hrem_q, wout_q, psc_pkg::PH_LOG2);
	wire [psc_pkg::PV_LOG2-1:0] vph = vph_w[psc_pkg::PV_LOG2-1:0];
	wire [psc_pkg::PH_LOG2-1:0] hph = hph_w[psc_pkg::PH_LOG2-1:0];
	wire vmir = sym_q && (vph > (1 << (psc_pkg::PV_LOG2 - 1)));
	wire hmir = sym_q && (hph > (1 << (psc_pkg::PH_LOG2 - 1)));
	wire [psc_pkg::PV_LOG2-1:0] vph_e = vmir ?
		psc_pkg::PV_LOG2'((1 << psc_pkg::PV_LOG2) - vph) : vph;
	wire [psc_pkg::PH_LOG2-1:0] hph_e = hmir ?
		psc_pkg::PH_LOG2'((1 << psc_pkg::PH_LOG2) - hph) : hph;
	wire [1:0] vtap_e = vmir ? 2'd3 - k_q : k_q;

	// Coefficient stores; bank bit selects the page being written
	wire [HA-1:0] hwa = {wr_bank_q, caddr_q[3:2]};
	wire hcf_wr = wr & hit_hcf;
	always_ff @(posedge pclk) begin
		if (hcf_wr) begin
			hmem[hwa][caddr_q[1:0]*CW +: CW] <= pwdata[CW-1:0];
		end
	end

	wire [CW*psc_pkg::NH-1:0] hword = hmem[{act_bank_q, hph_e}];
	logic [CW-1:0] vc_rd;

	if (psc_pkg::SHARE_COEF) begin : g_share
		// Vertical taps come from the horizontal page, no second store
		assign vc_rd = hmem[{act_bank_q, psc_pkg::PH_LOG2'(vph_e)}]
			[vtap_e*CW +: CW];
	end else begin : g_vmem
		logic [CW-1:0] vmem [psc_pkg::VDEPTH];
		always_ff @(posedge pclk) begin
			if (wr & hit_vcf) begin
				vmem[{wr_bank_q, caddr_q}] <= pwdata[CW-1:0];
			end
		end
		assign vc_rd = vmem[VA'({act_bank_q, vph_e, vtap_e})];
	end

	// Input side: lines land in buffer (row mod 4)
	wire in_fire  = in_valid & in_ready_q;
	wire in_eol_w = icol_q == win_q - SZ'(1);
	wire start    = (state_q == psc_pkg::PSC_IDLE) & go_q;
	wire room     = {1'b0, lines_q} <= {1'b0, vq_q} + (SZ+1)'(2);
	wire ready_d  = busy & (lines_q < hin_q) & ~(in_fire & in_eol_w) &
		((state_q == psc_pkg::PSC_DRAIN) | room);
	wire [SZ:0] need = ({1'b0, vq_q} + (SZ+1)'(2) < {1'b0, hin_q}) ?
		{1'b0, vq_q} + (SZ+1)'(2) : {1'b0, hin_q} - (SZ+1)'(1);
	wire rows_ok  = {1'b0, lines_q} > need;

	always_ff @(posedge pclk) begin
		if (in_fire) begin
			lbuf[lines_q[1:0]][icol_q[psc_pkg::LB_AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_q    <= '0;
			icol_q     <= '0;
			in_ready_q <= 1'b0;
		end else begin
			in_ready_q <= ready_d;
			if (start) begin
				lines_q <= '0;
				icol_q  <= '0;
			end else if (in_fire) begin
				icol_q  <= in_eol_w ? '0 : icol_q + SZ'(1);
				lines_q <= in_eol_w ? lines_q + SZ'(1) : lines_q;
			end
		end
	end

	// Vertical multiply-sum over one column of the 4x4 window
	wire [SZ-1:0] colk = tap_pos(hq_q, k_q, win_q);
	logic [4*VM-1:0] va_flat, vb_flat;
	logic [4*HM-1:0] ha_flat, hb_flat;
	logic signed [VSW-1:0] vsum;
	logic signed [HSW-1:0] hsum;

	for (genvar t = 0; t < 4; t++) begin : g_tap
		wire [SZ-1:0] rowt = tap_pos(vq_q, 2'(t), hin_q);
		wire [1:0] ht = hmir ? 2'(3 - t) : 2'(t);
		assign va_flat[t*VM +: VM] = VM'({1'b0,
			lbuf[rowt[1:0]][colk[psc_pkg::LB_AW-1:0]]});
		assign vb_flat[t*VM +: VM] = VM'($signed(vcoef_q[t]));
		assign ha_flat[t*HM +: HM] = HM'($signed(hreg_q[t]));
		assign hb_flat[t*HM +: HM] = HM'($signed(hword[ht*CW +: CW]));
	end

	psc_mac4 #(.W(VM)) u_vmac (
		.a_flat (va_flat),
		.b_flat (vb_flat),
		.sum    (vsum)
	);
	psc_mac4 #(.W(HM)) u_hmac (
		.a_flat (ha_flat),
		.b_flat (hb_flat),
		.sum    (hsum)
	);

	// Precision cuts: column result to kernel width, pixel to output
	wire signed [VSW-1:0] vsh = vsum >>> psc_pkg::CFRAC;
	wire signed [HSW-1:0] hsh = hsum >>> psc_pkg::CFRAC;
	wire signed [VSW-1:0] vsat = (vsh > KMAX) ? KMAX :
		(vsh < KMIN) ? KMIN : vsh;
	wire signed [HSW-1:0] hsat = (hsh > OMAX) ? OMAX :
		(hsh < 0) ? '0 : hsh;
	wire [psc_pkg::KW-1:0] vred = vsat[psc_pkg::KW-1:0];
	wire [7:0] hred = hsat[7:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= psc_pkg::PSC_IDLE;
			act_bank_q  <= 1'b0;
			{oi_q, oj_q, hq_q, vq_q} <= '0;
			{hrem_q, vrem_q} <= '0;
			k_q         <= 2'h0;
			out_valid_q <= 1'b0;
			out_data_q  <= 8'h00;
			out_sof_q   <= 1'b0;
			out_eol_q   <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				vcoef_q[i] <= '0;
				hreg_q[i]  <= '0;
			end
		end else begin
			unique case (state_q)
			psc_pkg::PSC_IDLE: if (start) begin
				// Bank choice frozen for the whole frame
				act_bank_q <= rd_bank_q;
				{oi_q, oj_q, hq_q, vq_q} <= '0;
				{hrem_q, vrem_q} <= '0;
				k_q     <= 2'h0;
				state_q <= psc_pkg::PSC_VLOAD;
			end
			psc_pkg::PSC_VLOAD: begin
				vcoef_q[k_q] <= vc_rd;
				k_q <= k_q + 2'h1;
				if (k_q == 2'h3) state_q <= psc_pkg::PSC_RWAIT;
			end
			psc_pkg::PSC_RWAIT: if (rows_ok) state_q <= psc_pkg::PSC_COLS;
			psc_pkg::PSC_COLS: begin
				hreg_q[k_q] <= vred;
				k_q <= k_q + 2'h1;
				if (k_q == 2'h3) state_q <= psc_pkg::PSC_OUTP;
			end
			psc_pkg::PSC_OUTP: if (!out_valid_q) begin
				out_data_q  <= hred;
				out_valid_q <= 1'b1;
				out_sof_q   <= (oi_q == '0) && (oj_q == '0);
				out_eol_q   <= oi_q == wout_q - SZ'(1);
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
				oi_q    <= oi_q + SZ'(1);
				hrem_q  <= hrem_q + {1'b0, win_q};
				state_q <= psc_pkg::PSC_HNORM;
			end
			psc_pkg::PSC_HNORM: if (hrem_q >= {1'b0, wout_q}) begin
				hrem_q <= hrem_q - {1'b0, wout_q};
				hq_q   <= hq_q + SZ'(1);
			end else if (oi_q == wout_q) begin
				{oi_q, hq_q} <= '0;
				hrem_q  <= '0;
				oj_q    <= oj_q + SZ'(1);
				vrem_q  <= vrem_q + {1'b0, hin_q};
				state_q <= psc_pkg::PSC_VNORM;
			end else begin
				state_q <= psc_pkg::PSC_COLS;
			end
			psc_pkg::PSC_VNORM: if (vrem_q >= {1'b0, hout_q}) begin
				vrem_q <= vrem_q - {1'b0, hout_q};
				vq_q   <= vq_q + SZ'(1);
			end else begin
				state_q <= (oj_q == hout_q) ? psc_pkg::PSC_DRAIN :
					psc_pkg::PSC_VLOAD;
			end
			psc_pkg::PSC_DRAIN: if (lines_q == hin_q) begin
				state_q <= psc_pkg::PSC_IDLE;
			end
			default: state_q <= psc_pkg::PSC_IDLE;
			endcase
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign in_ready  = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data  = out_data_q;
	assign out_sof   = out_sof_q;
	assign out_eol   = out_eol_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_lines: assert property (
		in_ready_q |-> lines_q < hin_q)
		else $error("input accepted past the frame height");
	chk_bank_frozen: assert property (
		busy && $past(busy) |-> $stable(act_bank_q))
		else $error("read bank changed inside a frame");
	chk_bank_sel: assert property (
		wr && hit_bank |=> rd_bank_q == $past(pwdata[psc_pkg::BANK_RD]) &&
			wr_bank_q == $past(pwdata[psc_pkg::BANK_WR]))
		else $error("bank selections not taken independently");
	chk_cols_four: assert property (
		state_q == psc_pkg::PSC_RWAIT && rows_ok |=>
			state_q == psc_pkg::PSC_COLS [*4] ##1
			state_q == psc_pkg::PSC_OUTP)
		else $error("column gather did not take four cycles");
	chk_vload_four: assert property (
		start |=> state_q == psc_pkg::PSC_VLOAD [*4] ##1
			state_q == psc_pkg::PSC_RWAIT)
		else $error("vertical coefficient load not four cycles");
	chk_hold_out: assert property (
		out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
		else $error("output pixel dropped under back-pressure");
	chk_phase_norm: assert property (
		state_q == psc_pkg::PSC_COLS |-> hrem_q < {1'b0, wout_q} &&
			vrem_q < {1'b0, hout_q})
		else $error("phase remainder not normalised");
	chk_centre_tap: assert property (
		state_q == psc_pkg::PSC_COLS && k_q == 2'h1 |->
			colk == hq_q)
		else $error("kernel centre not on source column");
endmodule
`default_nettype wire

/* verification/psc_stream_model.sv */
// Video source and sink facing the scaler core's stream ports.
// Assumes the bench pulses go only while the core is idle.
`timescale 1ns/1ps
`default_nettype none
module psc_stream_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic [1:0] n_frames,
	input  wire logic       stall,
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic [7:0]      in_data,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_data,
	input  wire logic       out_sof,
	input  wire logic       out_eol,
	output logic            out_ready
);
	localparam logic [3:0] XLAST = 4'd7;
	logic [1:0] left_q;
	logic [3:0] x_q;
	logic [1:0] y_q;
	logic [7:0] last_q;
	logic [1:0] cyc_q;
	logic [7:0] cap_data [512];
	logic [1:0] cap_flag [512];
	int         n_out;
	wire        beat = in_valid && in_ready;
	wire        fin = beat && x_q == XLAST && y_q == 2'd3;
	wire  [1:0] left_nx = go ? n_frames : left_q - {1'b0, fin};
	// Gaps and back-pressure make the core wait on both sides
	wire        gap = stall && cyc_q == 2'd3;
	// Released data line shows the inverse so stale values cannot match
	assign in_data = in_valid ? {1'b0, y_q, x_q, 1'b0} : ~last_q;
	assign out_ready = !(stall && cyc_q[0]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q   <= 2'd0;
			x_q      <= 4'd0;
			y_q      <= 2'd0;
			last_q   <= 8'h00;
			cyc_q    <= 2'd0;
			in_valid <= 1'b0;
		end else begin
			cyc_q  <= cyc_q + 2'd1;
			left_q <= left_nx;
			if (beat) begin
				last_q <= in_data;
				x_q    <= (x_q == XLAST) ? 4'd0 : x_q + 4'd1;
				y_q    <= (x_q == XLAST) ? y_q + 2'd1 : y_q;
			end
			// An offered pixel is held until taken
			if (!in_valid || in_ready)
				in_valid <= (left_nx != 2'd0) && !gap;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			n_out <= 0;
		else if (out_valid && out_ready) begin
			cap_data[n_out] <= out_data;
			cap_flag[n_out] <= {out_sof, out_eol};
			n_out           <= n_out + 1;
		end
	end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the scaler core: APB host plus stream partner.
// Assumes frames of 8x4 input pixels and the core's register map.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        go;
	logic        stall;
	logic [1:0]  n_frames;
	logic [31:0] rd;
	logic        err;
	wire  [31:0] prdata;
	wire         pready, pslverr, in_ready, in_valid, out_ready;
	wire         out_valid, out_sof, out_eol;
	wire  [7:0]  in_data, out_data;
	int          n_fail, check_count, base;

	always #12.5 pclk = ~pclk;

	psc_core u_psc_core (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.out_valid(out_valid), .out_data(out_data), .out_sof(out_sof),
		.out_eol(out_eol), .out_ready(out_ready)
	);
	psc_stream_model u_psc_stream_model (
		.pclk(pclk), .presetn(presetn), .go(go), .n_frames(n_frames),
		.stall(stall), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .out_valid(out_valid), .out_data(out_data),
		.out_sof(out_sof), .out_eol(out_eol), .out_ready(out_ready)
	);

	task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		chk_word(n, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		chk_bit("pready", 1'b1, pready);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(string n, logic [7:0] a, logic [31:0] m,
			logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk_word(n, e, rd & m);
	endtask
	task automatic load_bank(int mode);
		logic [8:0] h;
		for (int p = 0; p < 4; p++)
			for (int t = 0; t < 4; t++) begin
				h = (mode == 1) ? 9'h040 : 9'h080;
				h = (t == ((mode == 2 && p == 2) ? 2 : 1)) ? h : 9'h000;
				// Empty last phase: only the symmetric fold can fill it
				h = (mode == 3 && p == 3) ? 9'h000 : h;
				apb(1'b1, psc_pkg::OFF_CADDR, {28'h000_0000, p[1:0], t[1:0]});
				apb(1'b1, psc_pkg::OFF_VCOEF,
					{23'h00_0000, (t == 1) ? 9'h080 : 9'h000});
				apb(1'b1, psc_pkg::OFF_HCOEF, {23'h00_0000, h});
			end
	endtask
	task automatic sizes(logic [11:0] iw, logic [11:0] ow);
		apb(1'b1, psc_pkg::OFF_INSZ, {16'h0004, 4'h0, iw});
		apb(1'b1, psc_pkg::OFF_OUTSZ, {16'h0004, 4'h0, ow});
	endtask
	task automatic feed(logic [1:0] n);
		n_frames <= n;
		go       <= 1'b1;
		@(posedge pclk);
		go       <= 1'b0;
	endtask
	task automatic wait_out(int n);
		for (int k = 0; k < 5000 && u_psc_stream_model.n_out < n; k++)
			@(posedge pclk);
		chk_bit("output count", 1'b1, u_psc_stream_model.n_out >= n);
	endtask
	// Mode 0 identity, 1 halved, 2 doubled width with next-pixel phase,
	// 3 fourfold width whose last phase is folded onto the next pixel
	task automatic chk_frame(int mode, int ow);
		int sx;
		logic [7:0] e;
		for (int y = 0; y < 4; y++)
			for (int x = 0; x < ow; x++) begin
				sx = (mode == 2) ? ((x > 14) ? 7 : (x + 1) / 2) :
					(mode == 3) ? x / 4 + ((x % 4 == 3 && x < 28) ? 1 : 0) : x;
				e = 8'(2 * (y * 16 + sx));
				e = (mode == 1) ? e >> 1 : e;
				chk_word("pixel", {24'h00_0000, e},
					{24'h00_0000, u_psc_stream_model.cap_data[base]});
				chk_bit("sof", x == 0 && y == 0,
					u_psc_stream_model.cap_flag[base][1]);
				chk_bit("eol", x == ow - 1,
					u_psc_stream_model.cap_flag[base][0]);
				base++;
			end
	endtask

	task automatic t_regs();
		rchk("ctrl", psc_pkg::OFF_CTRL, ALL, 32'h0000_0000);
		rchk("insz", psc_pkg::OFF_INSZ, ALL, 32'h0030_0040);
		rchk("outsz", psc_pkg::OFF_OUTSZ, ALL, 32'h0030_0040);
		rchk("bank", psc_pkg::OFF_BANK, ALL, 32'h0000_0000);
		apb(1'b1, psc_pkg::OFF_STAT, ALL);
		rchk("status", psc_pkg::OFF_STAT, ALL, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'h0000_0001);
		chk_bit("slverr write", 1'b1, err);
		rchk("unmapped", 8'h20, ALL, 32'h0000_0000);
		chk_bit("slverr read", 1'b1, err);
	endtask
	task automatic t_identity();
		apb(1'b1, psc_pkg::OFF_BANK, 32'h0000_0000);
		load_bank(0);
		sizes(12'h008, 12'h008);
		feed(2'd1);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0001);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0000);
		wait_out(base + 32);
		chk_frame(0, 8);
		chk_bit("in_ready after frame", 1'b0, in_ready);
		rchk("lines", psc_pkg::OFF_STAT, 32'h0FFF_0000, 32'h0004_0000);
	endtask
	task automatic t_swap();
		stall <= 1'b1;
		apb(1'b1, psc_pkg::OFF_BANK, 32'h0000_0100);
		load_bank(1);
		feed(2'd2);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0001);
		wait_out(base + 1);
		apb(1'b1, psc_pkg::OFF_BANK, 32'h0000_0001);
		rchk("bank held", psc_pkg::OFF_STAT, 32'h3, 32'h0000_0001);
		wait_out(base + 33);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0000);
		rchk("bank taken", psc_pkg::OFF_STAT, 32'h3, 32'h0000_0003);
		wait_out(base + 64);
		chk_frame(0, 8);
		chk_frame(1, 8);
	endtask
	task automatic t_upscale();
		apb(1'b1, psc_pkg::OFF_BANK, 32'h0000_0000);
		load_bank(2);
		sizes(12'h008, 12'h010);
		feed(2'd1);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0001);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0000);
		wait_out(base + 64);
		chk_frame(2, 16);
	endtask
	task automatic t_sym();
		apb(1'b1, psc_pkg::OFF_BANK, 32'h0000_0000);
		load_bank(3);
		sizes(12'h008, 12'h020);
		feed(2'd1);
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0003);
		// Run bit dropped, fold kept for the frame already started
		apb(1'b1, psc_pkg::OFF_CTRL, 32'h0000_0002);
		rchk("ctrl fold", psc_pkg::OFF_CTRL, ALL, 32'h0000_0002);
		wait_out(base + 128);
		chk_frame(3, 32);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		go = 1'b0;
		stall = 1'b0;
		n_frames = 2'd0;
		base = 0;
		n_fail = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		chk_bit("pready in reset", 1'b0, pready);
		chk_bit("out_valid in reset", 1'b0, out_valid);
		chk_bit("in_ready in reset", 1'b0, in_ready);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_identity();
		t_swap();
		t_upscale();
		t_sym();
		chk_word("total outputs", 32'd288, u_psc_stream_model.n_out);
		complete_run();
	end
	// Whole run needs a few thousand cycles; this margin only cuts hangs
	initial begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		complete_run();
	end
endmodule
`default_nettype wire
